// [hdl/lrpe_pkg.sv]
package lrpe_pkg;

  // ----------------------------------------------------------------------
  // Clocking
  // ----------------------------------------------------------------------
  localparam int          SYS_CLK_HZ  = 50_000_000;
  localparam int          BASE_CLK_HZ = 32768;
  localparam logic [25:0] ACC_STEP    = 26'(BASE_CLK_HZ);
  localparam logic [25:0] ACC_WRAP    = 26'(SYS_CLK_HZ);
  localparam int          PS_FAST_DIV = 16;
  localparam int          PS_SLOW_DIV = 512;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_ENABLE = 8'h00;
  localparam logic [7:0] IDX_CONFIG = 8'h08;
  localparam logic [7:0] IDX_PC0    = 8'h09;
  localparam logic [7:0] IDX_STATUS = 8'h0C;
  localparam logic [7:0] IDX_PROG0  = 8'h40;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int          ENA_LOG_BIT     = 6;
  localparam int          CFG_INT_CLK_BIT = 0;
  localparam int          CFG_DET_BIT     = 1;
  localparam logic [1:0]  CONFIG_RESET    = 2'h1;
  localparam logic [15:0] PROG_RESET      = 16'h0000;

  // ----------------------------------------------------------------------
  // Execution control codes, opcodes and command timing
  // ----------------------------------------------------------------------
  localparam logic [1:0] EXEC_HOLD     = 2'h0;
  localparam logic [1:0] EXEC_RUN      = 2'h2;
  localparam logic [2:0] OP_BRANCH     = 3'h5;
  localparam logic [2:0] OP_END        = 3'h6;
  localparam logic [2:0] OP_TRIG       = 3'h7;
  localparam logic [4:0] FIXED_TICKS   = 5'h10;
  localparam logic [1:0] EXT_IN_TICKS  = 2'h2;
  localparam logic [1:0] EXT_OUT_TICKS = 2'h3;
  localparam logic [7:0] PWM_MAX       = 8'hFF;

  typedef enum logic [1:0] {
    LRPE_IDLE,
    LRPE_RAMP,
    LRPE_FIXED,
    LRPE_TWAIT
  } lrpe_state_t;

endpackage

// [hdl/lrpe_engine.sv]
`timescale 1ns/1ps
module lrpe_engine #(
  parameter int ADDR_W = 10
) (
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              slow_clock_input_pin,
  input  wire logic              trigger_in_n,
  output logic                   trigger_out,
  output logic                   trigger_oe,
  output logic                   int_n,
  output logic      [7:0]        pwm_red,
  output logic      [7:0]        pwm_green,
  output logic      [7:0]        pwm_blue
);

  localparam int NCH = 3;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [25:0] acc_reg, acc_next;
  logic [25:0] acc_sum;
  logic        ext_prev_reg;
  logic        int_tick;
  logic        use_int;
  logic        tick;
  logic [7:0]  idx;
  logic        wr, rd, hit;
  logic [1:0]  config_reg, config_next;
  logic        log_reg, log_next;
  logic [1:0]  exec_reg [NCH];
  logic [1:0]  exec_next [NCH];
  logic [2:0]  status_reg, status_next;
  logic [15:0] mem_reg [NCH*16];
  logic [15:0] mem_next [NCH*16];
  logic [3:0]  recv_reg [NCH];
  logic [3:0]  recv_next [NCH];
  logic [1:0]  ext_in_reg, ext_in_next;
  logic [1:0]  ext_out_reg, ext_out_next;
  logic        ext_seen;
  logic [7:0]  pwm_out_reg [NCH];
  logic [7:0]  pwm_out_next [NCH];
  logic [3:0]  pc_reg [NCH];
  logic [7:0]  pwm_reg [NCH];
  logic        hold_req [NCH];
  logic        int_ev [NCH];
  logic [5:0]  send_m [NCH];
  logic [3:0]  clr_m [NCH];
  logic        pc_wr [NCH];

  // Log curve: exponent from the top three bits, mantissa from the rest.
  function automatic logic [7:0] lrpe_log(input logic [7:0] v);
    logic [12:0] w;
    w = 13'({1'b1, v[4:0]}) << v[7:5];
    lrpe_log = (v == 8'h00) ? 8'h00 : w[12:5];
  endfunction

  // ----------------------------------------------------------------------
  // Base clock tick
  // ----------------------------------------------------------------------
  // A phase accumulator gives a mean 32768 Hz tick without a fractional
  // divider; the jitter is one system clock, far below one tick.
  always_comb begin
    acc_sum  = acc_reg + lrpe_pkg::ACC_STEP;
    int_tick = acc_sum >= lrpe_pkg::ACC_WRAP;
    acc_next = int_tick ? acc_sum - lrpe_pkg::ACC_WRAP : acc_sum;
    use_int  = config_reg[lrpe_pkg::CFG_INT_CLK_BIT]
             | ~config_reg[lrpe_pkg::CFG_DET_BIT];
    tick     = use_int ? int_tick
             : (slow_clock_input_pin & ~ext_prev_reg);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      acc_reg      <= 26'h0000000;
      ext_prev_reg <= 1'b0;
    end else begin
      acc_reg      <= acc_next;
      ext_prev_reg <= slow_clock_input_pin;
    end
  end

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  // Zero wait states: every access completes in its first access cycle.
  always_comb begin
    idx     = paddr[9:2];
    wr      = psel & penable & pwrite;
    rd      = psel & penable & ~pwrite;
    hit     = (idx == lrpe_pkg::IDX_ENABLE) | (idx == lrpe_pkg::IDX_CONFIG)
            | (idx == lrpe_pkg::IDX_STATUS)
            | ((idx >= lrpe_pkg::IDX_PC0) && (idx < lrpe_pkg::IDX_PC0 + 8'h03))
            | ((idx >= lrpe_pkg::IDX_PROG0)
               && (idx < lrpe_pkg::IDX_PROG0 + 8'h30));
    pready  = 1'b1;
    pslverr = psel & penable & ~hit;
    prdata  = 32'h00000000;
    if (idx == lrpe_pkg::IDX_ENABLE) begin
      prdata[lrpe_pkg::ENA_LOG_BIT] = log_reg;
      prdata[5:0] = {exec_reg[0], exec_reg[1], exec_reg[2]};
    end else if (idx == lrpe_pkg::IDX_CONFIG) begin
      prdata[1:0] = config_reg;
    end else if (idx == lrpe_pkg::IDX_STATUS) begin
      prdata[2:0] = status_reg;
    end else if (idx >= lrpe_pkg::IDX_PROG0 && hit) begin
      prdata[15:0] = mem_reg[6'(idx - lrpe_pkg::IDX_PROG0)];
    end else if (hit) begin
      prdata[3:0] = pc_reg[2'(idx - lrpe_pkg::IDX_PC0)];
    end
  end

  // ----------------------------------------------------------------------
  // Control registers, status, program memory
  // ----------------------------------------------------------------------
  // Engine requests to go to hold override a same-cycle software write.
  always_comb begin
    config_next = config_reg;
    log_next    = log_reg;
    status_next = status_reg;
    mem_next    = mem_reg;
    if (wr && idx == lrpe_pkg::IDX_CONFIG) begin
      config_next = pwdata[1:0];
    end
    if (wr && idx == lrpe_pkg::IDX_ENABLE) begin
      log_next = pwdata[lrpe_pkg::ENA_LOG_BIT];
    end
    if (wr && idx >= lrpe_pkg::IDX_PROG0 && hit) begin
      mem_next[6'(idx - lrpe_pkg::IDX_PROG0)] = pwdata[15:0];
    end
    // A read clears status, but an event in the same cycle survives.
    if (rd && idx == lrpe_pkg::IDX_STATUS) begin
      status_next = 3'h0;
    end
    for (int c = 0; c < NCH; c++) begin
      exec_next[c] = exec_reg[c];
      if (wr && idx == lrpe_pkg::IDX_ENABLE) begin
        exec_next[c] = pwdata[5-2*c -: 2];
      end
      if (hold_req[c]) begin
        exec_next[c] = lrpe_pkg::EXEC_HOLD;
      end
      if (int_ev[c]) begin
        status_next[c] = 1'b1;
      end
      pc_wr[c] = wr && (idx == lrpe_pkg::IDX_PC0 + 8'(c))
               && (exec_reg[c] == lrpe_pkg::EXEC_HOLD);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      config_reg <= lrpe_pkg::CONFIG_RESET;
      log_reg    <= 1'b0;
      status_reg <= 3'h0;
      for (int c = 0; c < NCH; c++) begin
        exec_reg[c] <= lrpe_pkg::EXEC_HOLD;
      end
      for (int i = 0; i < NCH*16; i++) begin
        mem_reg[i] <= lrpe_pkg::PROG_RESET;
      end
    end else begin
      config_reg <= config_next;
      log_reg    <= log_next;
      status_reg <= status_next;
      exec_reg   <= exec_next;
      mem_reg    <= mem_next;
    end
  end

  assign int_n = ~|status_reg;

  // ----------------------------------------------------------------------
  // Triggers and output mapping
  // ----------------------------------------------------------------------
  // Received triggers are sticky; a new send wins over a same-cycle clear.
  // The input is ignored while this device drives the pin itself.
  always_comb begin
    ext_in_next  = ext_in_reg;
    ext_out_next = ext_out_reg;
    ext_seen     = 1'b0;
    if (trigger_in_n || ext_out_reg != 2'h0) begin
      ext_in_next = 2'h0;
    end else if (tick && ext_in_reg != lrpe_pkg::EXT_IN_TICKS) begin
      ext_in_next = ext_in_reg + 2'h1;
      ext_seen    = (ext_in_reg + 2'h1) == lrpe_pkg::EXT_IN_TICKS;
    end
    if (tick && ext_out_reg != 2'h0) begin
      ext_out_next = ext_out_reg - 2'h1;
    end
    for (int c = 0; c < NCH; c++) begin
      if (send_m[c][5]) begin
        ext_out_next = lrpe_pkg::EXT_OUT_TICKS;
      end
    end
    for (int t = 0; t < NCH; t++) begin
      recv_next[t] = recv_reg[t] & ~clr_m[t];
      recv_next[t][3] = recv_next[t][3] | ext_seen;
      for (int c = 0; c < NCH; c++) begin
        recv_next[t][c] = recv_next[t][c] | send_m[c][t];
      end
      pwm_out_next[t] = log_reg ? lrpe_log(pwm_reg[t]) : pwm_reg[t];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ext_in_reg  <= 2'h0;
      ext_out_reg <= 2'h0;
      for (int c = 0; c < NCH; c++) begin
        recv_reg[c]    <= 4'h0;
        pwm_out_reg[c] <= 8'h00;
      end
    end else begin
      ext_in_reg  <= ext_in_next;
      ext_out_reg <= ext_out_next;
      recv_reg    <= recv_next;
      pwm_out_reg <= pwm_out_next;
    end
  end

  assign trigger_out = 1'b0;
  assign trigger_oe  = ext_out_reg != 2'h0;
  assign pwm_red     = pwm_out_reg[0];
  assign pwm_green   = pwm_out_reg[1];
  assign pwm_blue    = pwm_out_reg[2];

  // ----------------------------------------------------------------------
  // Channel engines
  // ----------------------------------------------------------------------
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    lrpe_pkg::lrpe_state_t st_reg, st_next;
    logic [3:0]  pc_next;
    logic [7:0]  pwm_next;
    logic [14:0] tcnt_reg, tcnt_next, len_reg, len_next;
    logic [7:0]  steps_reg, steps_next;
    logic        dir_reg, dir_next, move_reg, move_next;
    logic [5:0]  wmask_reg, wmask_next;
    logic        act_reg [16];
    logic        act_next [16];
    logic [5:0]  rem_reg [16];
    logic [5:0]  rem_next [16];
    logic [15:0] cmd;
    logic [3:0]  need;

    // Fetch and decode on a tick when the channel is idle and not held.
    always_comb begin
      cmd        = mem_reg[{2'(c), pc_reg[c]}];
      need       = {wmask_reg[5], wmask_reg[2:0]};
      st_next    = st_reg;
      pc_next    = pc_reg[c];
      pwm_next   = pwm_reg[c];
      tcnt_next  = tcnt_reg;
      len_next   = len_reg;
      steps_next = steps_reg;
      dir_next   = dir_reg;
      move_next  = move_reg;
      wmask_next = wmask_reg;
      act_next   = act_reg;
      rem_next   = rem_reg;
      hold_req[c] = 1'b0;
      int_ev[c]   = 1'b0;
      send_m[c]   = 6'h00;
      clr_m[c]    = 4'h0;
      if (pc_wr[c]) begin
        pc_next = pwdata[3:0];
      end
      unique case (st_reg)
        lrpe_pkg::LRPE_IDLE: begin
          if (tick && exec_reg[c] != lrpe_pkg::EXEC_HOLD) begin
            hold_req[c] = exec_reg[c] != lrpe_pkg::EXEC_RUN;
            pc_next     = pc_reg[c] + 4'h1;
            st_next     = lrpe_pkg::LRPE_FIXED;
            tcnt_next   = 15'(lrpe_pkg::FIXED_TICKS);
            if (!cmd[15] && cmd[13:8] == 6'h00) begin
              if (cmd[14]) begin
                pwm_next = cmd[7:0];
              end else begin
                pc_next = 4'h0;
              end
            end else if (!cmd[15]) begin
              len_next   = 15'(cmd[13:8]) * (cmd[14]
                         ? 15'(lrpe_pkg::PS_SLOW_DIV)
                         : 15'(lrpe_pkg::PS_FAST_DIV));
              tcnt_next  = len_next;
              steps_next = {1'b0, cmd[6:0]} + 8'h01;
              dir_next   = cmd[7];
              move_next  = cmd[6:0] != 7'h00;
              st_next    = lrpe_pkg::LRPE_RAMP;
            end else if (cmd[15:13] == lrpe_pkg::OP_BRANCH) begin
              if (cmd[12:7] == 6'h00) begin
                pc_next = cmd[3:0];
              end else if (!act_reg[pc_reg[c]]) begin
                act_next[pc_reg[c]] = 1'b1;
                rem_next[pc_reg[c]] = cmd[12:7] - 6'h01;
                pc_next = cmd[3:0];
              end else if (rem_reg[pc_reg[c]] == 6'h00) begin
                act_next[pc_reg[c]] = 1'b0;
              end else begin
                rem_next[pc_reg[c]] = rem_reg[pc_reg[c]] - 6'h01;
                pc_next = cmd[3:0];
              end
            end else if (cmd[15:13] == lrpe_pkg::OP_END) begin
              pc_next     = 4'h0;
              hold_req[c] = 1'b1;
              int_ev[c]   = cmd[12];
              for (int i = 0; i < 16; i++) begin
                act_next[i] = 1'b0;
              end
              if (cmd[11]) begin
                pwm_next = 8'h00;
              end
            end else if (cmd[15:13] == lrpe_pkg::OP_TRIG) begin
              send_m[c]  = cmd[6:1];
              wmask_next = cmd[12:7];
            end
          end
        end
        lrpe_pkg::LRPE_RAMP: begin
          if (tick && tcnt_reg > 15'h0001) begin
            tcnt_next = tcnt_reg - 15'h0001;
          end else if (tick) begin
            // Saturate at the ends but keep timing the whole command.
            if (move_reg && !dir_reg && pwm_reg[c] != lrpe_pkg::PWM_MAX) begin
              pwm_next = pwm_reg[c] + 8'h01;
            end else if (move_reg && dir_reg && pwm_reg[c] != 8'h00) begin
              pwm_next = pwm_reg[c] - 8'h01;
            end
            steps_next = steps_reg - 8'h01;
            tcnt_next  = len_reg;
            if (steps_reg == 8'h01) begin
              st_next = lrpe_pkg::LRPE_IDLE;
            end
          end
        end
        lrpe_pkg::LRPE_FIXED: begin
          if (tick && tcnt_reg > 15'h0001) begin
            tcnt_next = tcnt_reg - 15'h0001;
          end else if (tick) begin
            st_next = (wmask_reg != 6'h00) ? lrpe_pkg::LRPE_TWAIT
                    : lrpe_pkg::LRPE_IDLE;
          end
        end
        lrpe_pkg::LRPE_TWAIT: begin
          if ((recv_reg[c] & need) == need) begin
            clr_m[c]   = need;
            wmask_next = 6'h00;
            st_next    = lrpe_pkg::LRPE_IDLE;
          end
        end
      endcase
    end

    always_ff @(posedge clk_sys) begin
      if (reset) begin
        st_reg     <= lrpe_pkg::LRPE_IDLE;
        pc_reg[c]  <= 4'h0;
        pwm_reg[c] <= 8'h00;
        tcnt_reg   <= 15'h0000;
        len_reg    <= 15'h0000;
        steps_reg  <= 8'h00;
        dir_reg    <= 1'b0;
        move_reg   <= 1'b0;
        wmask_reg  <= 6'h00;
        for (int i = 0; i < 16; i++) begin
          act_reg[i] <= 1'b0;
          rem_reg[i] <= 6'h00;
        end
      end else begin
        st_reg     <= st_next;
        pc_reg[c]  <= pc_next;
        pwm_reg[c] <= pwm_next;
        tcnt_reg   <= tcnt_next;
        len_reg    <= len_next;
        steps_reg  <= steps_next;
        dir_reg    <= dir_next;
        move_reg   <= move_next;
        wmask_reg  <= wmask_next;
        act_reg    <= act_next;
        rem_reg    <= rem_next;
      end
    end
  end

endmodule // lrpe_engine

// [tb/lrpe_engine_assertions.sv]
`timescale 1ns/1ps
module lrpe_engine_assertions #(
  parameter int ADDR_W = 10
) (
  input wire logic              clk_sys,
  input wire logic              reset,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              trigger_out,
  input wire logic              trigger_oe,
  input wire logic              int_n,
  input wire logic [7:0]        pwm_red,
  input wire logic [7:0]        pwm_green,
  input wire logic [7:0]        pwm_blue
);
  // --------------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------------
  logic [7:0] idx;
  logic       acc;
  logic       rd_acc;
  logic       mapped;
  logic       stat_rd;

  // Index decode mirrors the map so refusals can be told apart.
  assign idx     = 8'(paddr >> 2);
  assign acc     = psel && penable;
  assign rd_acc  = acc && !pwrite;
  assign stat_rd = rd_acc && (idx == lrpe_pkg::IDX_STATUS);
  assign mapped  = (idx == lrpe_pkg::IDX_ENABLE) ||
                   (idx >= lrpe_pkg::IDX_CONFIG && idx <= 8'h0C) ||
                   (idx >= lrpe_pkg::IDX_PROG0 && idx <= 8'h6F);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // --------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------
  a_bus_ready: assert property (acc |-> pready)
    else $error("access phase without ready");
  a_unmapped_err: assert property (acc |-> (pslverr == !mapped))
    else $error("error response does not match address map");
  a_unmapped_zero: assert property (rd_acc && !mapped |-> prdata == 32'h0)
    else $error("unmapped read returned data");
  a_cfg_rsvd: assert property (
    rd_acc && idx == lrpe_pkg::IDX_CONFIG |-> prdata[31:2] == 30'h0)
    else $error("config reserved bits not zero");
  a_pc_width: assert property (
    rd_acc && idx >= lrpe_pkg::IDX_PC0 && idx <= 8'h0B
    |-> prdata[31:4] == 28'h0)
    else $error("program counter wider than four bits");
  a_int_held: assert property (!int_n && !stat_rd |=> !int_n)
    else $error("interrupt released without status read");
  a_int_release: assert property ($rose(int_n) |-> $past(stat_rd))
    else $error("interrupt rose without status read");
  a_oe_span: assert property ($rose(trigger_oe) |-> trigger_oe[*4])
    else $error("trigger pulse too short");
  a_trig_level: assert property (trigger_out == 1'b0)
    else $error("trigger pin driven high");
  a_out_reset: assert property (disable iff (1'b0)
    reset |=> pwm_red == 8'h00 && pwm_green == 8'h00 &&
              pwm_blue == 8'h00 && int_n && !trigger_oe)
    else $error("outputs not cleared by reset");
endmodule // lrpe_engine_assertions

bind lrpe_engine lrpe_engine_assertions #(.ADDR_W(ADDR_W)) u_lrpe_chk (
  .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .trigger_out(trigger_out), .trigger_oe(trigger_oe),
  .int_n(int_n), .pwm_red(pwm_red), .pwm_green(pwm_green),
  .pwm_blue(pwm_blue)
);

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
  logic        clk_sys;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [9:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        slow_clk = 1'b0;
  logic        trigger_out;
  logic        trigger_oe;
  logic        int_n;
  logic [7:0]  pwm_red;
  logic [7:0]  pwm_green;
  logic [7:0]  pwm_blue;
  logic [1:0]  div_reg = 2'h0;
  logic [31:0] rd;
  logic        err;
  int          failures;
  int          check_count;
  int          cyc = 0;

  lrpe_engine uut (
    .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .slow_clock_input_pin(slow_clk),
    .trigger_in_n(1'b1), .trigger_out(trigger_out),
    .trigger_oe(trigger_oe), .int_n(int_n), .pwm_red(pwm_red),
    .pwm_green(pwm_green), .pwm_blue(pwm_blue)
  );

  // --------------------------------------------------------------------
  // Clocks
  // --------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Base tick every four clocks keeps long ramps affordable in time.
  always @(posedge clk_sys) begin
    div_reg  <= div_reg + 2'h1;
    slow_clk <= div_reg[1];
    cyc      <= cyc + 1;
  end

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; ends one edge after release so calls never collide.
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd, output logic [31:0] rdv,
                     output logic erv);
    int   n;
    logic rdy;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    // Answer is sampled settled, just before the edge that takes it.
    do begin
      @(negedge clk_sys);
      rdv = prdata;
      erv = pslverr;
      rdy = pready;
      @(posedge clk_sys);
      n++;
    end while (rdy !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      complete_run();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd, rd, err);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0, rd, err);
    check(rd, exp);
  endtask

  // Polls until the selected execution fields have fallen back to hold.
  task automatic wait_hold(input logic [31:0] mask);
    int n;
    n  = 0;
    rd = mask;
    while ((rd & mask) !== 32'h0 && n < 2000) begin
      apb(1'b0, lrpe_pkg::IDX_ENABLE, 32'h0, rd, err);
      n++;
    end
    if (n >= 2000) begin
      failures++;
      complete_run();
    end
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_reset();
    check({int_n, trigger_oe, pwm_red, pwm_green, pwm_blue}, 32'h2000000);
    rdc(lrpe_pkg::IDX_CONFIG, 32'h1);
    rdc(lrpe_pkg::IDX_ENABLE, 32'h0);
    rdc(8'h45, 32'h0);
    rdc(8'h20, 32'h0);
    check(err, 1'b1);
    wr(lrpe_pkg::IDX_CONFIG, 32'h2);
    rdc(lrpe_pkg::IDX_CONFIG, 32'h2);
  endtask

  // Ramp past full scale, then wait, then end with interrupt.
  task automatic t_ramp();
    wr(8'h40, 32'h40FD);
    wr(8'h41, 32'h0103);
    wr(8'h42, 32'h0180);
    wr(8'h43, 32'hD000);
    wr(lrpe_pkg::IDX_ENABLE, 32'h20);
    wait_hold(32'h30);
    check(pwm_red, 8'hFF);
    check(int_n, 1'b0);
    rdc(lrpe_pkg::IDX_STATUS, 32'h1);
    check(int_n, 1'b1);
    rdc(lrpe_pkg::IDX_PC0, 32'h0);
  endtask

  // Two-step ramp looped by a branch: three passes of two levels.
  task automatic t_loop();
    wr(8'h50, 32'h0101);
    wr(8'h51, 32'hA100);
    wr(8'h52, 32'hC000);
    wr(lrpe_pkg::IDX_ENABLE, 32'h08);
    wait_hold(32'h0C);
    check(pwm_green, 8'h06);
  endtask

  task automatic t_wrap();
    wr(lrpe_pkg::IDX_PC0, 32'hF);
    rdc(lrpe_pkg::IDX_PC0, 32'hF);
    wr(8'h4F, 32'h4033);
    wr(8'h40, 32'hC000);
    wr(lrpe_pkg::IDX_ENABLE, 32'h20);
    wait_hold(32'h30);
    check(pwm_red, 8'h33);
    check(int_n, 1'b1);
    rdc(lrpe_pkg::IDX_PC0, 32'h0);
  endtask

  task automatic t_log();
    int n;
    wr(8'h60, 32'hE040);
    wr(8'h61, 32'h40FF);
    wr(8'h62, 32'hC000);
    wr(lrpe_pkg::IDX_ENABLE, 32'h42);
    n = 0;
    while (trigger_oe !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    check(trigger_oe, 1'b1);
    check(trigger_out, 1'b0);
    wait_hold(32'h03);
    check(pwm_blue, 8'hFC);
    wr(lrpe_pkg::IDX_ENABLE, 32'h00);
    repeat (2) @(posedge clk_sys);
    check(pwm_blue, 8'hFF);
  endtask

  // A slow-prescale wait must last 512 base ticks, four clocks each.
  task automatic t_prescale();
    int t0;
    wr(8'h60, 32'h4100);
    wr(8'h61, 32'hC000);
    t0 = cyc;
    wr(lrpe_pkg::IDX_ENABLE, 32'h02);
    wait_hold(32'h03);
    check(32'(cyc - t0 >= 2048 && cyc - t0 <= 2300), 32'h1);
    check(pwm_blue, 8'hFF);
  endtask

  // --------------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------------
  initial begin
    reset       <= 1'b1;
    psel        <= 1'b0;
    penable     <= 1'b0;
    pwrite      <= 1'b0;
    paddr       <= 10'h000;
    pwdata      <= 32'h0;
    failures    = 0;
    check_count = 0;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_ramp();
    t_loop();
    t_wrap();
    t_log();
    t_prescale();
    complete_run();
  end

  // A hang counts as a mismatch and ends the run.
  initial begin
    repeat (100000) @(posedge clk_sys);
    failures++;
    complete_run();
  end
endmodule // testbench
